/* btc_params.svh */
`ifndef BTC_PARAMS_SVH
`define BTC_PARAMS_SVH
// register offsets
`define BTC_OFS_COMPLETION_TIMEOUT_CTRL   12'h050
`define BTC_OFS_CLKOUT_DEBUG  12'h054
`define BTC_OFS_DISCARD       12'h058
// reset values
`define BTC_RST_COMPLETION_TIMEOUT_CTRL   32'h8009_8968
`define BTC_RST_CLKOUT_DEBUG  32'h0000_1F00
`define BTC_RST_DISCARD       32'h0000_0100
// field positions
`define BTC_CPL_EN_BIT        31
`define BTC_CPL_PERIOD_MSB    30
`define BTC_CLK_GATE_LSB      8
`define BTC_CLK_GATE_MSB      12
`define BTC_UNLOCK_BIT        1
`define BTC_SCRAMBLE_DIS_BIT  0
`define BTC_SHORT_DISC_BIT    10
`define BTC_DISC_EN_BIT       8
// writable-bit masks, reserved bits read zero
`define BTC_MASK_COMPLETION_TIMEOUT_CTRL  32'hFFFF_FFFF
`define BTC_MASK_CLKOUT_DEBUG 32'h0000_1F03
`define BTC_MASK_DISCARD      32'h0000_0500
// bits that only loader writes or unlocked TLP writes may change
`define BTC_LOCK_COMPLETION_TIMEOUT_CTRL  32'hFFFF_FFFF
`define BTC_LOCK_CLKOUT_DEBUG 32'h0000_1F00
`define BTC_LOCK_DISCARD      32'h0000_0500
// timing
`define BTC_CLK_PERIOD_NS     10
`define BTC_STEP_NS           16
// discard timer load values
`define BTC_DISC_SHORT        16'h003F
`define BTC_DISC_1K           16'h03FF
`define BTC_DISC_32K          16'h7FFF
`endif

/* btc_pkg.sv */
`default_nettype none
package btc_pkg;
  // discard timer states, one-hot
  typedef enum logic [1:0] {
    DISC_IDLE = 2'b01,
    DISC_RUN  = 2'b10
  } btc_disc_state_t;
endpackage : btc_pkg
`default_nettype wire

/* btc_cpl_slot.sv */
`timescale 1ns/1ps
`default_nettype none
`include "btc_params.svh"
// one completion timer for one outstanding upstream non-posted request
module btc_cpl_slot (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        start,
  input  wire logic        stop,
  input  wire logic        retire,
  input  wire logic        tick,
  input  wire logic        enable,
  input  wire logic [30:0] period,
  output logic             busy,
  output logic             due
);
  logic        busy_q;
  logic        busy_d;
  logic [30:0] count_q;
  logic [30:0] count_d;

  // start wins over stop so a reused tag is never lost
  assign busy_d  = start | (busy_q & ~stop & ~retire);
  assign count_d = start ? 31'h0000_0000 : ((busy_q & tick & ~due) ? count_q + 31'h1 : count_q);
  // timer disabled means the request simply waits for its completion
  assign due     = busy_q & enable & (count_q >= period);
  assign busy    = busy_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_q  <= 1'b0;
      count_q <= 31'h0000_0000;
    end else begin
      busy_q  <= busy_d;
      count_q <= count_d;
    end
  end

  a_slot_retire_idle: assert property (@(posedge clk) disable iff (!nrst)
    (retire && !start) |=> !busy_q)
    else $error("slot still busy after retire");
endmodule : btc_cpl_slot
`default_nettype wire

/* btc_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "btc_params.svh"
// Function
// - with timeout enabled, expired non-posted request completes as Unsupported Request.
// - timeout period is bits 30:0, counted in 16 ns steps.
// - period resets to 0x0009_8968; all-ones gives about 34 s.
// - bits 12:8 gate five secondary clocks; 1 runs, reset all ones.
// - lockable bits take TLP writes only while unlock bit 1 is set.
// - loader writes from EEPROM or JTAG always change lockable bits.
// - debug bit 0 set turns scrambling off; reset value zero.
// - short discard bit 10 set loads discard timer with 0x003F, 64 secondary clock ticks.
// - short discard off loads 0x03FF or 0x7FFF.
// - discard timer runs only while enable bit 8 is set; resets set.
module btc_ctrl #(
  parameter int SLOTS = 4,
  parameter int TAG_W = 2
) (
  input  wire logic             CLOCK,
  input  wire logic             NRST,
  input  wire logic             TLP_WR,
  input  wire logic             TLP_RD,
  input  wire logic [11:0]      TLP_ADDR,
  input  wire logic [31:0]      TLP_WDATA,
  input  wire logic             LDR_WR,
  input  wire logic [11:0]      LDR_ADDR,
  input  wire logic [31:0]      LDR_WDATA,
  input  wire logic             REQ_FWD,
  input  wire logic [TAG_W-1:0] REQ_TAG,
  input  wire logic             CPL_RCV,
  input  wire logic [TAG_W-1:0] CPL_TAG,
  input  wire logic             SEC_CLK_TICK,
  input  wire logic             DISC_START,
  input  wire logic             DISC_CLEAR,
  input  wire logic             BRIDGE_DISC_SEL,
  output logic [31:0]           RDATA,
  output logic                  RD_VALID,
  output logic                  TIMEOUT_UR,
  output logic [TAG_W-1:0]      TIMEOUT_TAG,
  output logic [4:0]            SEC_CLK_GATES,
  output logic                  SCRAMBLE_DISABLE,
  output logic                  DISC_EXPIRED
);
  // refuse slot counts that the tag cannot address
  if (SLOTS < 1 || SLOTS > (1 << TAG_W)) begin : g_bad_slots
    $error("SLOTS must fit in TAG_W bits");
  end

  localparam int STEP_W = 6;
  localparam logic [STEP_W-1:0] STEP_ADD = STEP_W'(`BTC_CLK_PERIOD_NS);
  localparam logic [STEP_W-1:0] STEP_LEN = STEP_W'(`BTC_STEP_NS);

  // new value of one register after loader and TLP writes
  function automatic logic [31:0] reg_next(input logic [31:0] cur, input logic [11:0] ofs,
      input logic [31:0] mask, input logic [31:0] lock, input logic unlocked,
      input logic lw, input logic [11:0] la, input logic [31:0] ld,
      input logic tw, input logic [11:0] ta, input logic [31:0] td);
    logic [31:0] tmask;
    tmask = unlocked ? mask : (mask & ~lock);
    if (lw && la == ofs)
      reg_next = (cur & ~mask) | (ld & mask);
    else if (tw && ta == ofs)
      reg_next = (cur & ~tmask) | (td & tmask);
    else
      reg_next = cur;
  endfunction : reg_next

  logic [31:0] cpl_q, cpl_d, dbg_q, dbg_d, disc_q, disc_d;
  logic        unlocked;
  assign unlocked = dbg_q[`BTC_UNLOCK_BIT];
  // loader wins a same-cycle collision: it is the trusted configuration path
  assign cpl_d  = reg_next(cpl_q, `BTC_OFS_COMPLETION_TIMEOUT_CTRL, `BTC_MASK_COMPLETION_TIMEOUT_CTRL,
                           `BTC_LOCK_COMPLETION_TIMEOUT_CTRL, unlocked, LDR_WR, LDR_ADDR, LDR_WDATA,
                           TLP_WR, TLP_ADDR, TLP_WDATA);
  assign dbg_d  = reg_next(dbg_q, `BTC_OFS_CLKOUT_DEBUG, `BTC_MASK_CLKOUT_DEBUG,
                           `BTC_LOCK_CLKOUT_DEBUG, unlocked, LDR_WR, LDR_ADDR, LDR_WDATA,
                           TLP_WR, TLP_ADDR, TLP_WDATA);
  assign disc_d = reg_next(disc_q, `BTC_OFS_DISCARD, `BTC_MASK_DISCARD,
                           `BTC_LOCK_DISCARD, unlocked, LDR_WR, LDR_ADDR, LDR_WDATA,
                           TLP_WR, TLP_ADDR, TLP_WDATA);

  // read mux, unmapped offsets read zero
  logic [31:0] rd_mux;
  assign rd_mux = (TLP_ADDR == `BTC_OFS_COMPLETION_TIMEOUT_CTRL)  ? cpl_q :
                  (TLP_ADDR == `BTC_OFS_CLKOUT_DEBUG) ? dbg_q :
                  (TLP_ADDR == `BTC_OFS_DISCARD)      ? disc_q : 32'h0000_0000;

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      cpl_q    <= `BTC_RST_COMPLETION_TIMEOUT_CTRL;
      dbg_q    <= `BTC_RST_CLKOUT_DEBUG;
      disc_q   <= `BTC_RST_DISCARD;
      RDATA    <= 32'h0000_0000;
      RD_VALID <= 1'b0;
    end else begin
      cpl_q    <= cpl_d;
      dbg_q    <= dbg_d;
      disc_q   <= disc_d;
      RDATA    <= TLP_RD ? rd_mux : RDATA;
      RD_VALID <= TLP_RD;
    end
  end

  // clock gates and scramble control straight from register flops
  assign SEC_CLK_GATES    = dbg_q[`BTC_CLK_GATE_MSB:`BTC_CLK_GATE_LSB];
  assign SCRAMBLE_DISABLE = dbg_q[`BTC_SCRAMBLE_DIS_BIT];

  // 16 ns tick from a 10 ns clock by fractional accumulation; jitter is one clock
  logic [STEP_W-1:0] acc_q, acc_sum, acc_d;
  logic              tick_q, tick_d;
  assign acc_sum = acc_q + STEP_ADD;
  assign tick_d  = (acc_sum >= STEP_LEN);
  assign acc_d   = tick_d ? acc_sum - STEP_LEN : acc_sum;

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      acc_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      acc_q  <= acc_d;
      tick_q <= tick_d;
    end
  end

  // per-request timers
  logic [SLOTS-1:0] slot_due, slot_busy, slot_retire;
  genvar g;
  generate
    for (g = 0; g < SLOTS; g++) begin : g_slot
      btc_cpl_slot u_slot (
        .clk    (CLOCK),
        .nrst   (NRST),
        .start  (REQ_FWD && REQ_TAG == TAG_W'(g)),
        .stop   (CPL_RCV && CPL_TAG == TAG_W'(g)),
        .retire (slot_retire[g]),
        .tick   (tick_q),
        .enable (cpl_q[`BTC_CPL_EN_BIT]),
        .period (cpl_q[`BTC_CPL_PERIOD_MSB:0]),
        .busy   (slot_busy[g]),
        .due    (slot_due[g])
      );
    end
  endgenerate

  // lowest due slot is reported first; others wait their turn
  logic [SLOTS-1:0] due_low;
  logic [TAG_W-1:0] due_tag;
  assign due_low     = slot_due & (~slot_due + SLOTS'(1));
  assign slot_retire = due_low;
  always_comb begin
    due_tag = '0;
    for (int i = 0; i < SLOTS; i++) begin
      if (due_low[i]) due_tag = TAG_W'(i);
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      TIMEOUT_UR  <= 1'b0;
      TIMEOUT_TAG <= '0;
    end else begin
      TIMEOUT_UR  <= |slot_due;
      TIMEOUT_TAG <= due_tag;
    end
  end

  // secondary discard timer, counted in secondary clock ticks
  logic [15:0]               disc_load, disc_cnt_q, disc_cnt_d;
  btc_pkg::btc_disc_state_t  dstate_q, dstate_d;
  logic                      disc_on, disc_fire;
  assign disc_on   = disc_q[`BTC_DISC_EN_BIT];
  assign disc_load = disc_q[`BTC_SHORT_DISC_BIT] ? `BTC_DISC_SHORT :
                     (BRIDGE_DISC_SEL ? `BTC_DISC_1K : `BTC_DISC_32K);
  assign disc_fire = (dstate_q == btc_pkg::DISC_RUN) && SEC_CLK_TICK
                     && disc_cnt_q == 16'h0000 && !DISC_CLEAR && disc_on;

  always_comb begin
    dstate_d   = dstate_q;
    disc_cnt_d = disc_cnt_q;
    case (dstate_q)
      btc_pkg::DISC_IDLE: begin
        if (DISC_START && disc_on) begin
          dstate_d   = btc_pkg::DISC_RUN;
          disc_cnt_d = disc_load;
        end
      end
      btc_pkg::DISC_RUN: begin
        if (!disc_on || DISC_CLEAR || disc_fire) begin
          dstate_d = btc_pkg::DISC_IDLE;
        end else if (SEC_CLK_TICK) begin
          disc_cnt_d = disc_cnt_q - 16'h0001;
        end
      end
      default: dstate_d = btc_pkg::DISC_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      dstate_q     <= btc_pkg::DISC_IDLE;
      disc_cnt_q   <= 16'h0000;
      DISC_EXPIRED <= 1'b0;
    end else begin
      dstate_q     <= dstate_d;
      disc_cnt_q   <= disc_cnt_d;
      DISC_EXPIRED <= disc_fire;
    end
  end

  a_lock_holds_cpl: assert property (@(posedge CLOCK) disable iff (!NRST)
    (TLP_WR && !LDR_WR && !unlocked && TLP_ADDR == `BTC_OFS_COMPLETION_TIMEOUT_CTRL) |=> $stable(cpl_q))
    else $error("locked timeout register changed by TLP");
  a_loader_writes: assert property (@(posedge CLOCK) disable iff (!NRST)
    (LDR_WR && LDR_ADDR == `BTC_OFS_COMPLETION_TIMEOUT_CTRL) |=> cpl_q == $past(LDR_WDATA))
    else $error("loader write to timeout register lost");
  a_gates_follow: assert property (@(posedge CLOCK) disable iff (!NRST)
    (LDR_WR && LDR_ADDR == `BTC_OFS_CLKOUT_DEBUG) |=> SEC_CLK_GATES == $past(LDR_WDATA[12:8]))
    else $error("clock gates do not follow register");
  a_scramble_bit: assert property (@(posedge CLOCK) disable iff (!NRST)
    (TLP_WR && !LDR_WR && TLP_ADDR == `BTC_OFS_CLKOUT_DEBUG) |=> SCRAMBLE_DISABLE == $past(TLP_WDATA[0]))
    else $error("scramble disable does not follow write");
  a_zero_period: assert property (@(posedge CLOCK) disable iff (!NRST)
    (REQ_FWD && !CPL_RCV && cpl_q[31] && cpl_q[30:0] == 31'h0
     && !LDR_WR && !TLP_WR) |=> ##1 TIMEOUT_UR)
    else $error("zero period did not time out at once");
  a_timeout_off: assert property (@(posedge CLOCK) disable iff (!NRST)
    !$past(cpl_q[`BTC_CPL_EN_BIT]) |-> !TIMEOUT_UR)
    else $error("timeout reported while disabled");
  a_short_load: assert property (@(posedge CLOCK) disable iff (!NRST)
    (dstate_q == btc_pkg::DISC_IDLE && DISC_START && disc_on && disc_q[10])
    |=> disc_cnt_q == 16'h003F)
    else $error("short discard did not load 63");
  a_long_load: assert property (@(posedge CLOCK) disable iff (!NRST)
    (dstate_q == btc_pkg::DISC_IDLE && DISC_START && disc_on && !disc_q[10])
    |=> disc_cnt_q == ($past(BRIDGE_DISC_SEL) ? 16'h03FF : 16'h7FFF))
    else $error("long discard load wrong");
  a_disc_disabled: assert property (@(posedge CLOCK) disable iff (!NRST)
    !disc_on |=> dstate_q == btc_pkg::DISC_IDLE && !DISC_EXPIRED)
    else $error("discard timer ran while disabled");
endmodule : btc_ctrl
`default_nettype wire

/* btc_far_end.sv */
`timescale 1ns/1ps
`default_nettype none
// far side: secondary clock ticks and an upstream completer
module btc_far_end #(
  parameter int TICK_DIV  = 3,
  parameter int CPL_DELAY = 5
) (
  input  wire logic       CLOCK,
  input  wire logic       NRST,
  input  wire logic       REPLY_EN,
  input  wire logic       REQ_FWD,
  input  wire logic [1:0] REQ_TAG,
  output logic            SEC_CLK_TICK,
  output logic            CPL_RCV,
  output logic [1:0]      CPL_TAG
);
  int         div_q;
  int         wait_q;
  logic [1:0] tag_q;
  // one tick per secondary clock period
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      div_q <= 0;
      SEC_CLK_TICK <= 1'b0;
    end else begin
      div_q <= (div_q == TICK_DIV - 1) ? 0 : div_q + 1;
      SEC_CLK_TICK <= (div_q == TICK_DIV - 1);
    end
  end
  // one late completion per request; tag toggles when idle so stale values never match
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      wait_q <= 0;
      tag_q <= 2'h0;
      CPL_RCV <= 1'b0;
      CPL_TAG <= 2'h0;
    end else begin
      if (REQ_FWD && REPLY_EN) begin
        wait_q <= CPL_DELAY;
        tag_q <= REQ_TAG;
      end else if (wait_q > 0) begin
        wait_q <= wait_q - 1;
      end
      CPL_RCV <= (wait_q == 1);
      CPL_TAG <= (wait_q == 1) ? tag_q : ~CPL_TAG;
    end
  end
endmodule : btc_far_end
`default_nettype wire

/* tb_bridge_timeout_clock_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "btc_params.svh"
module tb_bridge_timeout_clock_ctrl;
  logic CLOCK = 0, NRST = 0, TLP_WR = 0, TLP_RD = 0, LDR_WR = 0, REQ_FWD = 0;
  logic DISC_START = 0, DISC_CLEAR = 0, BRIDGE_DISC_SEL = 1, REPLY_EN = 0;
  logic [11:0] TLP_ADDR = 0, LDR_ADDR = 0;
  logic [31:0] TLP_WDATA = 0, LDR_WDATA = 0, RDATA, d;
  logic [1:0] REQ_TAG = 0, CPL_TAG, TIMEOUT_TAG;
  logic CPL_RCV, SEC_CLK_TICK, RD_VALID, TIMEOUT_UR, SCRAMBLE_DISABLE, DISC_EXPIRED;
  logic [4:0] SEC_CLK_GATES;
  logic [33:0] exp_q[$];
  int fails = 0, checks = 0, ticks = 0, cyc = 0;
  always #5 CLOCK = ~CLOCK;
  btc_ctrl btc_ctrl_i (.CLOCK(CLOCK), .NRST(NRST), .TLP_WR(TLP_WR), .TLP_RD(TLP_RD),
    .TLP_ADDR(TLP_ADDR), .TLP_WDATA(TLP_WDATA), .LDR_WR(LDR_WR), .LDR_ADDR(LDR_ADDR),
    .LDR_WDATA(LDR_WDATA), .REQ_FWD(REQ_FWD), .REQ_TAG(REQ_TAG), .CPL_RCV(CPL_RCV),
    .CPL_TAG(CPL_TAG), .SEC_CLK_TICK(SEC_CLK_TICK), .DISC_START(DISC_START),
    .DISC_CLEAR(DISC_CLEAR), .BRIDGE_DISC_SEL(BRIDGE_DISC_SEL), .RDATA(RDATA),
    .RD_VALID(RD_VALID), .TIMEOUT_UR(TIMEOUT_UR), .TIMEOUT_TAG(TIMEOUT_TAG),
    .SEC_CLK_GATES(SEC_CLK_GATES), .SCRAMBLE_DISABLE(SCRAMBLE_DISABLE),
    .DISC_EXPIRED(DISC_EXPIRED));
  btc_far_end btc_far_end_i (.CLOCK(CLOCK), .NRST(NRST), .REPLY_EN(REPLY_EN),
    .REQ_FWD(REQ_FWD), .REQ_TAG(REQ_TAG), .SEC_CLK_TICK(SEC_CLK_TICK),
    .CPL_RCV(CPL_RCV), .CPL_TAG(CPL_TAG));
  task automatic test_done;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // monitor side: every result takes the oldest note off the queue
  task automatic see(input logic [1:0] k, input logic [31:0] v);
    logic [33:0] e;
    e = (exp_q.size() != 0) ? exp_q.pop_front() : 34'h3_FFFF_FFFF;
    chk("event kind", {30'h0, e[33:32]}, {30'h0, k});
    chk("event value", e[31:0], v);
  endtask : see
  // sampled at the falling edge, well clear of the edge that launches outputs
  always @(negedge CLOCK) begin
    cyc++;
    if (cyc == 9000) begin
      fails++;
      test_done();
    end
    if (RD_VALID === 1'b1) see(2'd0, RDATA);
    if (TIMEOUT_UR === 1'b1) see(2'd1, {30'h0, TIMEOUT_TAG});
    if (DISC_EXPIRED === 1'b1) see(2'd2, ticks);
    // ticks counted from the edge after the discard start
    if (DISC_START) ticks = 0;
    else if (SEC_CLK_TICK) ticks++;
  end
  task automatic tick1;
    @(posedge CLOCK);
    #1;
  endtask : tick1
  task automatic tlp_wr(input logic [11:0] a, input logic [31:0] v);
    TLP_WR = 1; TLP_ADDR = a; TLP_WDATA = v; tick1(); TLP_WR = 0; tick1();
  endtask : tlp_wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back({2'd0, e});
    TLP_RD = 1; TLP_ADDR = a; tick1(); TLP_RD = 0; tick1();
  endtask : rd
  task automatic pulse_req;
    REQ_TAG = 2'($urandom); REQ_FWD = 1; tick1(); REQ_FWD = 0;
  endtask : pulse_req
  task automatic pulse_disc;
    DISC_START = 1; tick1(); DISC_START = 0;
  endtask : pulse_disc
  task automatic ldr_wr(input logic [11:0] a, input logic [31:0] v);
    LDR_WR = 1;
    LDR_ADDR = a;
    LDR_WDATA = v;
    tick1();
    LDR_WR = 0;
    tick1();
  endtask : ldr_wr
  // arm the discard timer, then take the transaction before it can expire
  task automatic disc_abort(input logic [31:0] v);
    tlp_wr(`BTC_OFS_DISCARD, v);
    pulse_disc();
    repeat (20) tick1();
    DISC_CLEAR = 1;
    tick1();
    DISC_CLEAR = 0;
    tick1();
  endtask : disc_abort
  // wait for every note to be met, then idle to catch strays
  task automatic drain(input int idle);
    for (int i = 0; i < 4000 && exp_q.size() != 0; i++) tick1();
    chk("pending", 0, exp_q.size());
    repeat (idle) tick1();
  endtask : drain
  initial begin
    void'($urandom(32'hf9edaa45));
    repeat (4) @(posedge CLOCK);
    #1 NRST = 1;
    tick1();
    rd(`BTC_OFS_COMPLETION_TIMEOUT_CTRL, `BTC_RST_COMPLETION_TIMEOUT_CTRL);
    rd(`BTC_OFS_CLKOUT_DEBUG, `BTC_RST_CLKOUT_DEBUG);
    rd(`BTC_OFS_DISCARD, `BTC_RST_DISCARD);
    rd(12'h05C, 32'h0);
    tlp_wr(`BTC_OFS_COMPLETION_TIMEOUT_CTRL, 32'h0);
    rd(`BTC_OFS_COMPLETION_TIMEOUT_CTRL, `BTC_RST_COMPLETION_TIMEOUT_CTRL);
    ldr_wr(`BTC_OFS_COMPLETION_TIMEOUT_CTRL, 32'h8000_0003);
    rd(`BTC_OFS_COMPLETION_TIMEOUT_CTRL, 32'h8000_0003);
    pulse_req();
    exp_q.push_back({2'd1, 30'h0, REQ_TAG});
    drain(20);
    // two tags in flight at period zero, each times out on its own timer
    ldr_wr(`BTC_OFS_COMPLETION_TIMEOUT_CTRL, 32'h8000_0000);
    REQ_TAG = 2'($urandom % 3);
    REQ_FWD = 1;
    tick1();
    exp_q.push_back({2'd1, 30'h0, REQ_TAG});
    REQ_TAG = REQ_TAG + 2'h1;
    tick1();
    REQ_FWD = 0;
    exp_q.push_back({2'd1, 30'h0, REQ_TAG});
    drain(20);
    // loader reaches the locked gates; the unlocking TLP write cannot yet
    ldr_wr(`BTC_OFS_CLKOUT_DEBUG, 32'h0000_0A01);
    rd(`BTC_OFS_CLKOUT_DEBUG, 32'h0000_0A01);
    d = ($urandom & 32'h0000_1F01) | 32'h2;
    tlp_wr(`BTC_OFS_CLKOUT_DEBUG, d | 32'hFFFF_E0FC);
    rd(`BTC_OFS_CLKOUT_DEBUG, 32'h0000_0A02 | (d & 32'h1));
    tlp_wr(`BTC_OFS_CLKOUT_DEBUG, d | 32'hFFFF_E0FC);
    rd(`BTC_OFS_CLKOUT_DEBUG, d);
    chk("gates", {27'h0, d[12:8]}, {27'h0, SEC_CLK_GATES});
    chk("scramble", {31'h0, d[0]}, {31'h0, SCRAMBLE_DISABLE});
    // a completion back in time keeps its timer quiet
    tlp_wr(`BTC_OFS_COMPLETION_TIMEOUT_CTRL, 32'h8000_0100);
    REPLY_EN = 1;
    pulse_req();
    drain(500);
    REPLY_EN = 0;
    tlp_wr(`BTC_OFS_COMPLETION_TIMEOUT_CTRL, 32'h0);
    pulse_req();
    drain(30);
    tlp_wr(`BTC_OFS_DISCARD, 32'h500);
    pulse_disc();
    exp_q.push_back({2'd2, 16'h0, `BTC_DISC_SHORT + 16'h1});
    drain(5);
    tlp_wr(`BTC_OFS_DISCARD, 32'h100);
    pulse_disc();
    exp_q.push_back({2'd2, 16'h0, `BTC_DISC_1K + 16'h1});
    drain(5);
    tlp_wr(`BTC_OFS_DISCARD, 32'h400);
    pulse_disc();
    drain(250);
    // long period chosen by the bridge select, then cleared runs
    BRIDGE_DISC_SEL = 0;
    disc_abort(32'h100);
    BRIDGE_DISC_SEL = 1;
    disc_abort(32'h500);
    drain(250);
    test_done();
  end
endmodule : tb_bridge_timeout_clock_ctrl
`default_nettype wire
